// [irqf_edge_det.sv]
// edge detector for one group of pins: two-flop sync then edge compare
// assumes pins are asynchronous to aclk
`timescale 1ns/1ps
module irqf_edge_det #(
    parameter int N = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] pin,
    input wire logic [N-1:0] rise_sel,
    output logic [N-1:0] edge_hit
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] last_q;
    // synchroniser and history; pins idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '1;
            sync_q <= '1;
            last_q <= '1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    // per pin edge choice
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            assign edge_hit[i] = rise_sel[i] ? (sync_q[i] & ~last_q[i])
                                             : (~sync_q[i] & last_q[i]);
        end
    endgenerate
endmodule

// [irqf_pins_model.sv]
// model of the pins and peripherals that surround the flag block
// assumes aclk from the bench; pins are pulled up, so they idle high
`timescale 1ns/1ps
module irqf_pins_model (
    input wire logic aclk,
    output logic [4:0] external_irq_pin,
    output logic [7:0] wake_pin,
    output logic serial1_done,
    output logic timer_tick
);
    // idle levels from time zero, pull-ups hold the pins high
    initial begin
        external_irq_pin = 5'h1F;
        wake_pin = 8'hFF;
        serial1_done = 1'b0;
        timer_tick = 1'b0;
    end
    // external pin levels change just after an edge
    task automatic set_ext(input logic [4:0] v);
        @(posedge aclk);
        external_irq_pin <= v;
    endtask
    // wake pin levels change just after an edge
    task automatic set_wake(input logic [7:0] v);
        @(posedge aclk);
        wake_pin <= v;
    endtask
    // end of a serial transfer, held two cycles for the synchroniser
    task automatic serial_end();
        @(posedge aclk);
        serial1_done <= 1'b1;
        repeat (2) @(posedge aclk);
        serial1_done <= 1'b0;
    endtask
    // n back-to-back count enables for the timer
    task automatic ticks(input int n);
        @(posedge aclk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge aclk);
        timer_tick <= 1'b0;
    endtask
endmodule

// [irqf_pkg.sv]
// package for the interrupt request flag block: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package irqf_pkg;
    // register word indices; the byte address is four times the index
    localparam logic [7:0] IRQF_IDX_REQ1 = 8'hF6;
    localparam logic [7:0] IRQF_IDX_WAKE = 8'hF7;
    localparam logic [7:0] IRQF_IDX_MASK1 = 8'hF8;
    localparam logic [7:0] IRQF_IDX_WAKE_MASK = 8'hF9;
    localparam logic [7:0] IRQF_IDX_PIN_CFG = 8'hFA;
    localparam logic [7:0] IRQF_IDX_WAKE_CFG = 8'hFB;
    localparam logic [7:0] IRQF_IDX_EDGE_SEL = 8'hFC;
    localparam logic [7:0] IRQF_IDX_TIMER = 8'hFD;
    // field positions in the first request register, then the external and wake pin counts
    localparam int IRQF_BIT_TIMER = 7;
    localparam int IRQF_BIT_SERIAL1 = 6;
    localparam int IRQF_BIT_FIXED = 5;
    localparam int IRQF_NUM_EXT = 5;
    localparam int IRQF_NUM_WAKE = 8;
    // reset values and the timer maximum
    localparam logic [7:0] IRQF_RST_REQ1 = 8'h20;
    localparam logic [7:0] IRQF_RST_WAKE = 8'h00;
    localparam logic [7:0] IRQF_RST_CFG = 8'h00;
    localparam logic [7:0] IRQF_TIMER_MAX = 8'hFF;
    // bus responses
    localparam logic [1:0] IRQF_RESP_OKAY = 2'h0;
    localparam logic [1:0] IRQF_RESP_SLVERR = 2'h2;
    // write channel states
    typedef enum logic [2:0] {
        IRQF_W_IDLE = 3'b001,
        IRQF_W_RESP = 3'b010,
        IRQF_W_HOLD = 3'b100
    } irqf_wstate_t;
endpackage

// [irqf_tb_top.sv]
// self-checking bench for the flag block, integer model of both flag registers
// assumes the pins model beside the design and AXI4-Lite driven from here
`timescale 1ns/1ps
module interrupt_request_flags_tb_top;
    localparam logic [31:0] addr_req1 = {22'h0, irqf_pkg::IRQF_IDX_REQ1, 2'b00};
    localparam logic [31:0] addr_wake = {22'h0, irqf_pkg::IRQF_IDX_WAKE, 2'b00};
    localparam logic [31:0] addr_mask1 = {22'h0, irqf_pkg::IRQF_IDX_MASK1, 2'b00};
    localparam logic [31:0] addr_wmask = {22'h0, irqf_pkg::IRQF_IDX_WAKE_MASK, 2'b00};
    localparam logic [31:0] addr_pcfg = {22'h0, irqf_pkg::IRQF_IDX_PIN_CFG, 2'b00};
    localparam logic [31:0] addr_wcfg = {22'h0, irqf_pkg::IRQF_IDX_WAKE_CFG, 2'b00};
    localparam logic [31:0] addr_edge = {22'h0, irqf_pkg::IRQF_IDX_EDGE_SEL, 2'b00};
    localparam logic [31:0] addr_tmr = {22'h0, irqf_pkg::IRQF_IDX_TIMER, 2'b00};
    logic aclk, aresetn, irq, serial1_done, timer_tick;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [4:0] external_irq_pin;
    logic [7:0] wake_pin;
    logic [31:0] d;
    int n_fail = 0;
    int n_compared = 0;
    int exp_req1, exp_wake, sel, en, p, c, i, seed;

    irqf_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .external_irq_pin, .wake_pin, .serial1_done, .timer_tick, .irq);
    irqf_pins_model pins (.aclk, .external_irq_pin, .wake_pin, .serial1_done, .timer_tick);

    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // verdict and end of run
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic miss(input string m);
        n_fail++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask
    // compare tasks, one per kind of result
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) miss($sformatf("reg got %h exp %h", got, exp));
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) miss($sformatf("resp got %h exp %h", got, exp));
    endtask
    task automatic chk_irq(input logic exp);
        n_compared++;
        if (irq !== exp) miss($sformatf("irq got %b exp %b", irq, exp));
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                done = 1;
                rs = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    // one read, rready held until rvalid
    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                done = 1;
                v = s_axi_rdata;
                rs = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr_ok(input logic [31:0] a, input logic [31:0] v);
        wr(a, v, r);
        chk_resp(r, irqf_pkg::IRQF_RESP_OKAY);
    endtask
    task automatic rd_chk(input logic [31:0] a, input int e);
        rd(a, d, r);
        chk_resp(r, irqf_pkg::IRQF_RESP_OKAY);
        chk_reg(d, 32'(e));
    endtask
    // flag clear model: zero clears, one leaves the bit alone, bit 5 fixed
    task automatic clr_req1(input int v);
        wr_ok(addr_req1, 32'(v));
        exp_req1 = (exp_req1 & v) | 'h20;
    endtask
    // watchdog far beyond the expected run length
    initial begin
        repeat (30000) @(posedge aclk);
        miss("timeout");
        report_and_stop();
    end
    // main sequence
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        seed = $urandom(32'h6596);
        exp_req1 = 'h20;
        exp_wake = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, unmapped and read-only places
        rd_chk(addr_req1, exp_req1);
        rd_chk(addr_wake, exp_wake);
        rd(32'h0000_0100, d, r);
        chk_resp(r, irqf_pkg::IRQF_RESP_SLVERR);
        chk_reg(d, 32'h0);
        wr(addr_tmr, 32'h0, r);
        chk_resp(r, irqf_pkg::IRQF_RESP_SLVERR);
        $display("test reset done");
        // external pins on random edge selects, each pin low then high
        wr_ok(addr_mask1, 32'h0);
        wr_ok(addr_wmask, 32'h0);
        wr_ok(addr_pcfg, 32'h1F);
        sel = $urandom & 'h1F;
        wr_ok(addr_edge, 32'(sel));
        for (i = 0; i < 5; i++) begin
            pins.set_ext(5'(~(1 << i)));
            repeat (6) @(posedge aclk);
            if (!sel[i]) exp_req1 |= 1 << i;
            rd_chk(addr_req1, exp_req1);
            pins.set_ext(5'h1F);
            repeat (6) @(posedge aclk);
            if (sel[i]) exp_req1 |= 1 << i;
            rd_chk(addr_req1, exp_req1);
        end
        // single-bit clear, full clear, then ones that must not set
        clr_req1(~(1 << 2));
        rd_chk(addr_req1, exp_req1);
        clr_req1(0);
        clr_req1('hFF);
        rd_chk(addr_req1, exp_req1);
        $display("test external done");
        // serial transfer end and timer wrap from max to zero
        pins.serial_end();
        repeat (6) @(posedge aclk);
        exp_req1 |= 'h40;
        rd_chk(addr_req1, exp_req1);
        pins.ticks(255);
        rd_chk(addr_tmr, irqf_pkg::IRQF_TIMER_MAX);
        rd_chk(addr_req1, exp_req1);
        pins.ticks(1);
        repeat (3) @(posedge aclk);
        exp_req1 |= 'h80;
        rd_chk(addr_req1, exp_req1);
        rd_chk(addr_tmr, 0);
        clr_req1('h7F);
        rd_chk(addr_req1, exp_req1);
        $display("test serial timer done");
        // wake pins: random enables, random falling pattern, random clear
        en = $urandom & 'hFF;
        p = $urandom & 'hFF;
        c = $urandom & 'hFF;
        wr_ok(addr_wcfg, 32'(en));
        pins.set_wake(8'(~p));
        repeat (6) @(posedge aclk);
        exp_wake = p & en;
        rd_chk(addr_wake, exp_wake);
        pins.set_wake(8'hFF);
        repeat (6) @(posedge aclk);
        rd_chk(addr_wake, exp_wake);
        wr_ok(addr_wake, 32'(c));
        exp_wake &= c;
        rd_chk(addr_wake, exp_wake);
        $display("test wake done");
        // interrupt output: masked, enabled, then cleared; a one enables a flag
        chk_irq(1'b0);
        wr_ok(addr_mask1, 32'hFF);
        repeat (3) @(posedge aclk);
        chk_irq((exp_req1 & 'hDF) != 0);
        wr_ok(addr_wmask, 32'hFF);
        clr_req1(0);
        repeat (3) @(posedge aclk);
        chk_irq(exp_wake != 0);
        wr_ok(addr_wake, 32'h0);
        exp_wake = 0;
        repeat (3) @(posedge aclk);
        chk_irq(1'b0);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule

// [irqf_timer.sv]
// 8-bit free counter that pulses on wrap from max to zero
// assumes a one-cycle count enable from the surrounding logic
`timescale 1ns/1ps
module irqf_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic count_en,
    output logic [7:0] count,
    output logic wrap
);
    logic [7:0] count_q;
    // count and wrap detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 8'h00;
        end else if (count_en) begin
            count_q <= count_q + 8'h01;
        end
    end
    assign wrap = count_en && (count_q == irqf_pkg::IRQF_TIMER_MAX);
    assign count = count_q;
endmodule

// [irqf_top.sv]
// interrupt request flags with AXI4-Lite register access
// assumes pins asynchronous, serial done pulse and tick on aclk
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module irqf_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] external_irq_pin,
    input wire logic [7:0] wake_pin,
    input wire logic serial1_done,
    input wire logic timer_tick,
    output logic irq
);
    localparam int NE = irqf_pkg::IRQF_NUM_EXT;
    localparam int NW = irqf_pkg::IRQF_NUM_WAKE;

    logic [7:0] req1_q;
    logic [7:0] wake_q;
    logic [7:0] mask1_q;
    logic [7:0] wmask_q;
    logic [7:0] pin_cfg_q;
    logic [7:0] wake_cfg_q;
    logic [7:0] edge_sel_q;
    logic irq_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic have_aw_q;
    logic have_w_q;
    irqf_pkg::irqf_wstate_t wstate_q;
    logic wr_fire;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic [7:0] aw_word;
    logic [7:0] ar_word;
    logic [NE-1:0] ext_hit;
    logic [NW-1:0] wake_hit;
    logic tmr_wrap;
    logic [7:0] tmr_count;
    logic ser_meta_q;
    logic ser_sync_q;
    logic ser_last_q;
    logic [7:0] clr1;
    logic [7:0] clrw;
    logic [7:0] set1;

    // pin edge detection, external pins follow their select bit
    irqf_edge_det #(.N(NE)) u_ext (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(external_irq_pin),
        .rise_sel(edge_sel_q[NE-1:0]),
        .edge_hit(ext_hit)
    );
    // wake pins always falling
    irqf_edge_det #(.N(NW)) u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(wake_pin),
        .rise_sel(8'h00),
        .edge_hit(wake_hit)
    );
    irqf_timer u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .count_en(timer_tick),
        .count(tmr_count),
        .wrap(tmr_wrap)
    );

    // serial done may come from a slower domain: sync and detect rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_meta_q <= 1'b0;
            ser_sync_q <= 1'b0;
            ser_last_q <= 1'b0;
        end else begin
            ser_meta_q <= serial1_done;
            ser_sync_q <= ser_meta_q;
            ser_last_q <= ser_sync_q;
        end
    end

    // write and read address decode: byte offset = index * 4
    assign aw_word = awaddr_q[9:2];
    assign ar_word = s_axi_araddr[9:2];
    assign wr_fire = have_aw_q && have_w_q && (wstate_q == irqf_pkg::IRQF_W_IDLE);
    assign wr_lane = wstrb_q[0];
    assign wr_byte = wdata_q[7:0];

    // write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awaddr_q <= s_axi_awaddr;
                have_aw_q <= 1'b1;
                awready_q <= 1'b0;
            end else if (wr_fire) begin
                have_aw_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                have_w_q <= 1'b1;
                wready_q <= 1'b0;
            end else if (wr_fire) begin
                have_w_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // write response state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_q <= irqf_pkg::IRQF_W_IDLE;
            bvalid_q <= 1'b0;
            bresp_q <= irqf_pkg::IRQF_RESP_OKAY;
        end else begin
            case (wstate_q)
                irqf_pkg::IRQF_W_IDLE: begin
                    if (wr_fire) begin
                        bvalid_q <= 1'b1;
                        bresp_q <= (aw_word >= irqf_pkg::IRQF_IDX_REQ1 &&
                                    aw_word <= irqf_pkg::IRQF_IDX_EDGE_SEL) ?
                                   irqf_pkg::IRQF_RESP_OKAY : irqf_pkg::IRQF_RESP_SLVERR;
                        wstate_q <= irqf_pkg::IRQF_W_RESP;
                    end
                end
                irqf_pkg::IRQF_W_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_q <= 1'b0;
                        wstate_q <= irqf_pkg::IRQF_W_HOLD;
                    end
                end
                irqf_pkg::IRQF_W_HOLD: begin
                    wstate_q <= irqf_pkg::IRQF_W_IDLE;
                end
                default: begin
                    wstate_q <= irqf_pkg::IRQF_W_IDLE;
                    bvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // software clear masks: a zero written clears, a one does nothing
    assign clr1 = (wr_fire && wr_lane && aw_word == irqf_pkg::IRQF_IDX_REQ1) ?
                  ~wr_byte : 8'h00;
    assign clrw = (wr_fire && wr_lane && aw_word == irqf_pkg::IRQF_IDX_WAKE) ?
                  ~wr_byte : 8'h00;

    // hardware set sources for the first request register
    always_comb begin
        set1 = 8'h00;
        set1[irqf_pkg::IRQF_BIT_TIMER] = tmr_wrap;
        set1[irqf_pkg::IRQF_BIT_SERIAL1] = ser_sync_q & ~ser_last_q;
        set1[NE-1:0] = ext_hit & pin_cfg_q[NE-1:0];
    end

    // first request register: set wins over clear, bit 5 fixed at one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req1_q <= irqf_pkg::IRQF_RST_REQ1;
        end else begin
            req1_q <= (req1_q & ~clr1) | set1;
            req1_q[irqf_pkg::IRQF_BIT_FIXED] <= 1'b1;
        end
    end

    // wake register: eight independent flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_q <= irqf_pkg::IRQF_RST_WAKE;
        end else begin
            wake_q <= (wake_q & ~clrw) | (wake_hit & wake_cfg_q);
        end
    end

    // plain configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask1_q <= irqf_pkg::IRQF_RST_CFG;
            wmask_q <= irqf_pkg::IRQF_RST_CFG;
            pin_cfg_q <= irqf_pkg::IRQF_RST_CFG;
            wake_cfg_q <= irqf_pkg::IRQF_RST_CFG;
            edge_sel_q <= irqf_pkg::IRQF_RST_CFG;
        end else if (wr_fire && wr_lane) begin
            case (aw_word)
                irqf_pkg::IRQF_IDX_MASK1: mask1_q <= wr_byte;
                irqf_pkg::IRQF_IDX_WAKE_MASK: wmask_q <= wr_byte;
                irqf_pkg::IRQF_IDX_PIN_CFG: pin_cfg_q <= wr_byte;
                irqf_pkg::IRQF_IDX_WAKE_CFG: wake_cfg_q <= wr_byte;
                irqf_pkg::IRQF_IDX_EDGE_SEL: edge_sel_q <= wr_byte;
                default: mask1_q <= mask1_q;
            endcase
        end
    end

    // interrupt level: any unmasked flag, fixed bit excluded
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(req1_q & mask1_q & ~(8'h01 << irqf_pkg::IRQF_BIT_FIXED)) |
                     |(wake_q & wmask_q);
        end
    end

    // read channel: one read at a time, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= irqf_pkg::IRQF_RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= irqf_pkg::IRQF_RESP_OKAY;
            case (ar_word)
                irqf_pkg::IRQF_IDX_REQ1: rdata_q <= {24'h000000, req1_q};
                irqf_pkg::IRQF_IDX_WAKE: rdata_q <= {24'h000000, wake_q};
                irqf_pkg::IRQF_IDX_MASK1: rdata_q <= {24'h000000, mask1_q};
                irqf_pkg::IRQF_IDX_WAKE_MASK: rdata_q <= {24'h000000, wmask_q};
                irqf_pkg::IRQF_IDX_PIN_CFG: rdata_q <= {24'h000000, pin_cfg_q};
                irqf_pkg::IRQF_IDX_WAKE_CFG: rdata_q <= {24'h000000, wake_cfg_q};
                irqf_pkg::IRQF_IDX_EDGE_SEL: rdata_q <= {24'h000000, edge_sel_q};
                irqf_pkg::IRQF_IDX_TIMER: rdata_q <= {24'h000000, tmr_count};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= irqf_pkg::IRQF_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;

    // checks
    a_zero_clears_ext: assert property (@(posedge aclk) disable iff (!aresetn)
        (clr1[0] && !set1[0]) |=> !req1_q[0])
        else $error("ext flag not cleared by zero write");
    a_serial_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        (ser_sync_q && !ser_last_q) |=> req1_q[irqf_pkg::IRQF_BIT_SERIAL1])
        else $error("serial flag not set");
    a_one_no_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (!wake_q[3] && !(wake_hit[3] && wake_cfg_q[3])) |=> !wake_q[3])
        else $error("wake flag set without edge");
    a_wake_falls: assert property (@(posedge aclk) disable iff (!aresetn)
        (wake_cfg_q[0] && $fell(wake_pin[0]) ##2 wake_cfg_q[0]) |=> wake_q[0])
        else $error("wake edge not caught");
    a_wake_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        (wake_hit[0] && wake_cfg_q[0]) |=> wake_q[0])
        else $error("wake flag missed");
    a_wake_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (clrw[1] && !wake_hit[1]) |=> !wake_q[1])
        else $error("wake flag not cleared");
    a_fixed_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        req1_q[irqf_pkg::IRQF_BIT_FIXED])
        else $error("fixed bit lost");
    a_ext_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        (ext_hit[2] && pin_cfg_q[2]) |=> req1_q[2])
        else $error("ext edge not flagged");
    a_timer_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        tmr_wrap |=> (req1_q[irqf_pkg::IRQF_BIT_TIMER] && tmr_count == 8'h00))
        else $error("timer wrap not flagged");
    a_ext_no_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (set1[NE-1:0] == 5'h00) |=> ((req1_q[NE-1:0] & ~$past(req1_q[NE-1:0])) == 5'h00))
        else $error("ext flag set without edge");
    // bus and interrupt output checks
    a_timer_ro: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && aw_word == irqf_pkg::IRQF_IDX_TIMER) |=>
        (bvalid_q && bresp_q == irqf_pkg::IRQF_RESP_SLVERR))
        else $error("timer write not refused");
    a_irq_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(wake_q & wmask_q)) |=> irq_q)
        else $error("irq low with unmasked wake flag");
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid_q && !s_axi_rready) |=> (rvalid_q && $stable(rdata_q)))
        else $error("read answer dropped early");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (bvalid_q && !s_axi_bready) |=> (bvalid_q && $stable(bresp_q)))
        else $error("write answer dropped early");
    c_irq_rise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_q));
    c_serial_flag: cover property (@(posedge aclk) disable iff (!aresetn) $rose(req1_q[6]));
    c_timer_flag: cover property (@(posedge aclk) disable iff (!aresetn) $rose(req1_q[7]));
    c_wake_flag: cover property (@(posedge aclk) disable iff (!aresetn) $rose(wake_q[0]));
    c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
        bvalid_q && s_axi_bready);
endmodule
